// ==== asp_sync.sv ====
// Package for the serial port block, plus the pin input synchroniser.
// Assumes pins are asynchronous to i_clk_sys and change slower than a few clocks.
`timescale 1ns/1ps
`default_nettype none

package asp_pkg;
	localparam int COMM_BITS = 8;
	localparam int DATA_BITS = 24;
	localparam int CNT_W = 5;
	localparam int SEL_W = 3;
	localparam int READ_BIT = 6;
	localparam int SEL_LSB = 3;
	localparam logic [CNT_W-1:0] COMM_LAST = 5'h07;
	localparam logic [CNT_W-1:0] DATA_LAST = 5'h17;
	localparam logic [SEL_W-1:0] DATA_REG_SEL = 3'h3;
	localparam int SYNC_STAGES = 3;
	localparam int PIN_W = 4;
	localparam int PIN_SCLK = 0;
	localparam int PIN_CS = 1;
	localparam int PIN_DIN = 2;
	localparam int PIN_SYNC = 3;
	// Idle levels: clock high, select high, align high (pulled up)
	localparam logic [PIN_W-1:0] PIN_RESET = 4'hB;

	typedef enum logic [1:0] {
		ST_COMM = 2'h0,
		ST_RD = 2'h1,
		ST_WR = 2'h2
	} asp_phase_e;

	typedef struct packed {
		logic valid;
		logic [SEL_W-1:0] sel;
		logic [DATA_BITS-1:0] data;
	} asp_wr_s;

	typedef struct packed {
		asp_phase_e st;
		logic sclk_q;
		logic [CNT_W-1:0] cnt;
		logic [DATA_BITS-1:0] shin;
		logic [DATA_BITS-1:0] shout;
		logic [COMM_BITS-1:0] comm;
		logic load;
		logic rdy_n;
		logic pin;
		asp_wr_s wr;
	} asp_state_s;
endpackage

module asp_pin_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic [W-1:0] i_pin,
	output logic [W-1:0] o_lvl
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] lvl;
	} asp_sync_s;

	asp_sync_s q, d;

	// A change is accepted only when stages two and three agree
	always_comb begin
		d = q;
		d.s1 = i_pin;
		d.s2 = q.s1;
		d.s3 = q.s2;
		for (int i = 0; i < W; i++) begin
			if (q.s2[i] == q.s3[i]) begin
				d.lvl[i] = q.s3[i];
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= '{s1: INIT, s2: INIT, s3: INIT, lvl: INIT};
		end else begin
			q <= d;
		end
	end

	assign o_lvl = q.lvl;
endmodule

`default_nettype wire

// ==== asp_serial_port.sv ====
// Serial port and filter-align control of the converter's digital side.
// Assumes the register file answers i_rd_data combinationally from o_rd_sel.
`timescale 1ns/1ps
`default_nettype none

module asp_serial_port (
	input wire logic i_clk_sys,
	input wire logic i_rstn,
	input wire logic i_sclk,
	input wire logic i_cs_n,
	input wire logic i_din,
	input wire logic i_sync_n,
	input wire logic i_conv_done,
	input wire logic i_update_soon,
	input wire logic [asp_pkg::DATA_BITS-1:0] i_rd_data,
	output logic o_dout_rdy,
	output logic o_dout_oe_n,
	output logic o_filt_rst,
	output logic o_mod_rst,
	output logic [asp_pkg::SEL_W-1:0] o_rd_sel,
	output asp_pkg::asp_wr_s o_wr
);
	asp_pkg::asp_state_s q, d;
	logic [asp_pkg::PIN_W-1:0] lvl;
	logic sclk_f, cs_f, din_f, sync_f, rise, fall;
	logic [asp_pkg::COMM_BITS-1:0] comm_nx;

	asp_pin_sync #(
		.W(asp_pkg::PIN_W),
		.INIT(asp_pkg::PIN_RESET)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_rstn(i_rstn),
		.i_pin({i_sync_n, i_din, i_cs_n, i_sclk}),
		.o_lvl(lvl)
	);

	assign sclk_f = lvl[asp_pkg::PIN_SCLK];
	assign cs_f = lvl[asp_pkg::PIN_CS];
	assign din_f = lvl[asp_pkg::PIN_DIN];
	assign sync_f = lvl[asp_pkg::PIN_SYNC];
	assign rise = sclk_f & ~q.sclk_q;
	assign fall = ~sclk_f & q.sclk_q;
	assign comm_nx = {q.shin[asp_pkg::COMM_BITS-2:0], din_f};

	always_comb begin
		d = q;
		d.load = 1'b0;
		d.wr.valid = 1'b0;
		d.sclk_q = sclk_f;
		if (cs_f) begin
			// Deselect aborts any partial word and rearms for a command byte
			d.st = asp_pkg::ST_COMM;
			d.cnt = '0;
		end else begin
			if (rise) begin
				d.shin = {q.shin[asp_pkg::DATA_BITS-2:0], din_f};
				d.cnt = q.cnt + 5'h01;
				unique case (q.st)
					asp_pkg::ST_COMM: begin
						if (q.cnt == asp_pkg::COMM_LAST) begin
							d.cnt = '0;
							d.comm = comm_nx;
							if (comm_nx[asp_pkg::READ_BIT]) begin
								d.st = asp_pkg::ST_RD;
								d.load = 1'b1;
							end else begin
								d.st = asp_pkg::ST_WR;
							end
						end
					end
					asp_pkg::ST_WR: begin
						if (q.cnt == asp_pkg::DATA_LAST) begin
							d.cnt = '0;
							d.st = asp_pkg::ST_COMM;
							d.wr.valid = 1'b1;
							d.wr.sel = q.comm[asp_pkg::SEL_LSB +: asp_pkg::SEL_W];
							d.wr.data = {q.shin[asp_pkg::DATA_BITS-2:0], din_f};
						end
					end
					asp_pkg::ST_RD: begin
						if (q.cnt == asp_pkg::DATA_LAST) begin
							d.cnt = '0;
							d.st = asp_pkg::ST_COMM;
							// Reading the result retires its ready flag
							if (q.comm[asp_pkg::SEL_LSB +: asp_pkg::SEL_W] == asp_pkg::DATA_REG_SEL) begin
								d.rdy_n = 1'b1;
							end
						end
					end
				endcase
			end
			if (fall && q.st == asp_pkg::ST_RD) begin
				d.pin = q.shout[asp_pkg::DATA_BITS-1];
				d.shout = {q.shout[asp_pkg::DATA_BITS-2:0], 1'b0};
			end
		end
		if (q.load) begin
			d.shout = i_rd_data;
		end
		if (i_update_soon) begin
			d.rdy_n = 1'b1;
		end
		if (!sync_f) begin
			d.rdy_n = 1'b1;
		end
		// Set placed last so a completion wins over the update and read clears; align low blocks it
		if (i_conv_done && sync_f) begin
			d.rdy_n = 1'b0;
		end
		if (d.st != asp_pkg::ST_RD) begin
			d.pin = d.rdy_n;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= '{st: asp_pkg::ST_COMM, sclk_q: 1'b1, cnt: '0, shin: '0, shout: '0, comm: '0,
				load: 1'b0, rdy_n: 1'b1, pin: 1'b1, wr: '0};
		end else begin
			q <= d;
		end
	end

	// Held while the synchronised align level is low
	assign o_filt_rst = ~sync_f;
	assign o_mod_rst = ~sync_f;
	assign o_dout_rdy = q.pin;
	assign o_dout_oe_n = cs_f;
	assign o_rd_sel = q.comm[asp_pkg::SEL_LSB +: asp_pkg::SEL_W];
	assign o_wr = q.wr;

	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);

	sequence s_align_low;
		!i_sync_n [*6];
	endsequence
	sequence s_read_cmd;
		rise && q.st == asp_pkg::ST_COMM && q.cnt == asp_pkg::COMM_LAST && comm_nx[asp_pkg::READ_BIT] && !cs_f;
	endsequence

	property p_align_reset;
		s_align_low |-> o_filt_rst && o_mod_rst;
	endproperty
	a_align_reset: assert property (p_align_reset) else $error("align low did not reset filter");

	property p_align_rdy;
		o_filt_rst ##1 o_filt_rst |-> q.rdy_n ##1 (o_dout_rdy || q.st == asp_pkg::ST_RD);
	endproperty
	a_align_rdy: assert property (p_align_rdy) else $error("align did not force ready high");

	property p_align_keeps_port;
		o_filt_rst && !cs_f && !rise |=> $stable(q.cnt) && $stable(q.st);
	endproperty
	a_align_keeps_port: assert property (p_align_keeps_port) else $error("align disturbed serial state");

	property p_done_low;
		i_conv_done && sync_f |=> !q.rdy_n;
	endproperty
	a_done_low: assert property (p_done_low) else $error("ready not low after conversion");

	property p_update_high;
		i_update_soon && !i_conv_done |=> q.rdy_n;
	endproperty
	a_update_high: assert property (p_update_high) else $error("ready not high before update");

	property p_fall_shift;
		fall && !cs_f && q.st == asp_pkg::ST_RD |=> o_dout_rdy == $past(q.shout[asp_pkg::DATA_BITS-1]);
	endproperty
	a_fall_shift: assert property (p_fall_shift) else $error("output bit not from shift register");

	property p_read_load;
		s_read_cmd |=> q.load ##1 q.shout == $past(i_rd_data);
	endproperty
	a_read_load: assert property (p_read_load) else $error("read did not load shift register");

	property p_write_sel;
		o_wr.valid |-> $past(q.st) == asp_pkg::ST_WR && o_wr.sel == q.comm[asp_pkg::SEL_LSB +: asp_pkg::SEL_W];
	endproperty
	a_write_sel: assert property (p_write_sel) else $error("write not steered by command");

	property p_cs_frame;
		cs_f |=> q.cnt == '0 && q.st == asp_pkg::ST_COMM && !q.wr.valid;
	endproperty
	a_cs_frame: assert property (p_cs_frame) else $error("deselect did not rearm port");

	property p_burst_hold;
		!rise && !cs_f && !q.load |=> $stable(q.cnt) && $stable(q.shin);
	endproperty
	a_burst_hold: assert property (p_burst_hold) else $error("progress lost without clock");

	property p_sync_path;
		$fell(i_sync_n) ##1 !i_sync_n [*4] |-> o_filt_rst;
	endproperty
	a_sync_path: assert property (p_sync_path) else $error("align not seen after sync delay");

	// Outside the read phase the shared pin carries only the ready level
	property p_pin_shows_ready;
		q.st != asp_pkg::ST_RD |-> o_dout_rdy == q.rdy_n;
	endproperty
	a_pin_shows_ready: assert property (p_pin_shows_ready) else $error("pin not showing ready level");

	sequence s_data_read_end;
		rise && !cs_f && q.st == asp_pkg::ST_RD && q.cnt == asp_pkg::DATA_LAST;
	endsequence

	property p_read_retires;
		s_data_read_end ##0 (o_rd_sel == asp_pkg::DATA_REG_SEL && !i_conv_done) |=> q.rdy_n;
	endproperty
	a_read_retires: assert property (p_read_retires) else $error("result read left ready low");
endmodule

`default_nettype wire

// ==== asp_host.sv ====
// Host side model: drives serial clock, chip select and data in.
// Assumes the bench calls xfer from one process; clock idles high.
`timescale 1ns/1ps
`default_nettype none
module asp_host (
	input wire logic i_clk_sys,
	input wire logic i_dout,
	output logic o_sclk,
	output logic o_cs_n,
	output logic o_din
);
	initial begin
		o_sclk = 1'b1;
		o_cs_n = 1'b1;
		o_din = 1'b0;
	end
	// 16 system clocks per serial bit
	task automatic xfer(input logic [31:0] tx, input int nb, input bit keep, input int pause, output logic [31:0] rx);
		rx = '0;
		@(negedge i_clk_sys);
		o_cs_n = 1'b0;
		repeat (8) @(negedge i_clk_sys);
		for (int i = 31; i > 31 - nb; i--) begin
			o_sclk = 1'b0;
			o_din = tx[i];
			repeat (8) @(negedge i_clk_sys);
			rx[i] = i_dout;
			o_sclk = 1'b1;
			repeat (8) @(negedge i_clk_sys);
			if (i == pause) repeat (50) @(negedge i_clk_sys);
		end
		// Released line must not look like a held bit
		o_din = ~o_din;
		if (!keep) begin
			o_cs_n = 1'b1;
			// Deselect must outlast the pin filter or the frame never ends
			repeat (8) @(negedge i_clk_sys);
		end
	endtask
endmodule
`default_nettype wire

// ==== asp_serial_port_tb_top.sv ====
// Self-checking bench for the serial port with a host model.
// Assumes a combinational register file answering from o_rd_sel.
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_tb_top;
	logic clk, rstn, sclk, cs_n, din, sync_n, conv, upd, rdy, oe_n, frst, mrst;
	logic dout_line;
	logic [2:0] sel, s;
	logic [23:0] regs [8];
	logic [23:0] d;
	logic [31:0] rx;
	asp_pkg::asp_wr_s wr;
	asp_pkg::asp_wr_s exp_q[$];
	int n_mismatch = 0;
	int n_tests = 0;
	int cyc = 0;
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	asp_serial_port dut (.i_clk_sys(clk), .i_rstn(rstn), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
		.i_sync_n(sync_n), .i_conv_done(conv), .i_update_soon(upd), .i_rd_data(regs[sel]),
		.o_dout_rdy(rdy), .o_dout_oe_n(oe_n), .o_filt_rst(frst), .o_mod_rst(mrst), .o_rd_sel(sel), .o_wr(wr));
	// A released pin shows the opposite level so a stale bit cannot pass
	assign dout_line = oe_n ? ~rdy : rdy;
	asp_host host (.i_clk_sys(clk), .i_dout(dout_line), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
	task automatic chk(input logic [27:0] got, input logic [27:0] exp, input string what);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	always @(negedge clk) begin
		if (wr.valid === 1'b1) begin
			if (exp_q.size() == 0) chk(wr, '0, "unexpected write");
			else chk(wr, exp_q.pop_front(), "write");
		end
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			$display("Error %0t: timeout", $time);
			report_and_stop;
		end
	end
	task automatic wr_tx(input bit keep, input int pause);
		s = 3'($urandom);
		d = 24'($urandom);
		exp_q.push_back({1'b1, s, d});
		host.xfer({2'b00, s, 3'b000, d}, 32, keep, pause, rx);
	endtask
	task automatic rd_tx(input logic [2:0] rs);
		host.xfer({2'b01, rs, 27'h000_0000}, 32, 1'b0, -1, rx);
		chk(rx[23:0], regs[rs], "read");
	endtask
	task automatic ev(input bit c, input bit u);
		@(negedge clk);
		conv = c;
		upd = u;
		@(negedge clk);
		conv = 1'b0;
		upd = 1'b0;
		repeat (3) @(negedge clk);
	endtask
	initial begin
		rstn = 1'b0;
		sync_n = 1'b1;
		conv = 1'b0;
		upd = 1'b0;
		void'($urandom(7769));
		foreach (regs[i]) regs[i] = 24'($urandom);
		repeat (20) @(negedge clk);
		rstn = 1'b1;
		repeat (8) @(negedge clk);
		wr_tx(1'b0, -1);
		wr_tx(1'b0, 12);
		rd_tx(3'($urandom));
		rd_tx(3'($urandom));
		chk(oe_n, 28'h000_0001, "pin released");
		$display("test framed transfers done");
		// Aborted word must leave no write behind
		host.xfer({2'b00, 3'h5, 27'h123_4567}, 20, 1'b0, -1, rx);
		wr_tx(1'b1, -1);
		chk(oe_n, 28'h000_0000, "three-wire drives pin");
		wr_tx(1'b1, 20);
		rd_tx(3'($urandom));
		$display("test abort and three-wire done");
		ev(1'b1, 1'b0);
		chk(rdy, 28'h000_0000, "ready low");
		ev(1'b0, 1'b1);
		chk(rdy, 28'h000_0001, "ready back high");
		ev(1'b1, 1'b0);
		rd_tx(asp_pkg::DATA_REG_SEL);
		chk(28'(rx[31:24]), 28'h000_0000, "ready in command phase");
		chk(rdy, 28'h000_0001, "read retires ready");
		ev(1'b1, 1'b0);
		sync_n = 1'b0;
		@(negedge clk);
		chk(frst, 28'h000_0000, "align too early");
		repeat (8) @(negedge clk);
		chk(rdy, 28'h000_0001, "align forces ready");
		chk({mrst, frst}, 28'h000_0003, "filters held");
		ev(1'b1, 1'b0);
		chk(rdy, 28'h000_0001, "event under align");
		wr_tx(1'b0, -1);
		sync_n = 1'b1;
		repeat (8) @(negedge clk);
		chk({mrst, frst}, 28'h000_0000, "filters released");
		repeat (20) @(negedge clk);
		chk(28'(exp_q.size()), 28'h000_0000, "writes pending");
		$display("test ready and align done");
		report_and_stop;
	end
endmodule
`default_nettype wire
